// *** logic/slc_consts.svh ***
// Offsets, field positions, reset values and timing counts of the synthesizer control block
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH
`define SLC_ADDR_INT        4'h1
`define SLC_ADDR_NUM        4'h2
`define SLC_ADDR_DEN        4'h3
`define SLC_ADDR_FUNC       4'h4
`define SLC_CALIBRATION_TIME_SEL_HI        19
`define SLC_CALIBRATION_TIME_SEL_LO        16
`define SLC_LDCNT_BIT       14
`define SLC_LDSEL_BIT       13
`define SLC_SPEEDUP_ENABLE_BIT      11
`define SLC_FAST_HI         10
`define SLC_FAST_LO         7
`define SLC_HIZ_BIT         6
`define SLC_DSM_BIT         5
`define SLC_MODE_HI         3
`define SLC_MODE_LO         2
`define SLC_LVL_HI          1
`define SLC_LVL_LO          0
`define SLC_CPN_HI          18
`define SLC_CPN_LO          16
`define SLC_CPB_HI          14
`define SLC_CPB_LO          12
`define SLC_FIELD_HI        11
`define SLC_WORD_RST        20'h00000
`define SLC_FAST_BASE       14'h01FF
`define SLC_FAST_STEP       14'h0200
`define SLC_CAL_OFS         15'h0006
`define SLC_CAL_MUL         15'h0008
`define SLC_CAL_ADD         15'h0003
`define SLC_LOCK_N0         5'h0F
`define SLC_LOCK_N1         5'h1F
`define SLC_UNLOCK_N0       5'h03
`define SLC_UNLOCK_N1       5'h07
`endif

// *** logic/slc_pkg.sv ***
// Types of the synthesizer control block
package slc_pkg;
    typedef enum logic [1:0] {
        SLC_IDLE = 2'b00,
        SLC_CAL  = 2'b01,
        SLC_FAST = 2'b10,
        SLC_RUN  = 2'b11
    } slc_seq_e;
endpackage

// *** logic/slc_synth_ctrl.sv ***
// Lock, calibration and fast-lock control of a fractional-N synthesizer
`timescale 1ns/100ps
`include "slc_consts.svh"
module slc_synth_ctrl (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Register write port
    input  wire logic        reg_wr_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [19:0] reg_data_i,
    // Pins and comparator
    input  wire logic        power_down_n_i,
    input  wire logic        pfd_tick_i,
    input  wire logic        phase_good_i,
    input  wire logic        phase_raw_i,
    // Synthesizer settings
    output logic [11:0]      whole_divide_o,
    output logic [11:0]      numerator_value_o,
    output logic [11:0]      denominator_value_o,
    output logic             sigma_delta_enable_o,
    output logic [1:0]       local_mode_o,
    output logic [1:0]       local_out_level_o,
    output logic             local_port_enable_o,
    // Pump and oscillator control
    output logic [2:0]       pump_current_o,
    output logic             pump_tristate_o,
    output logic             tune_to_reference_o,
    output logic             calibrating_o,
    output logic             speedup_active_o,
    output logic             lock_indicator_o
);
    // Register storage and derived controls
    logic [19:0]        int_q, int_d, num_q, num_d, den_q, den_d, func_q, func_d;
    logic [11:0]        cnum_q, cnum_d, cden_q, cden_d;
    slc_pkg::slc_seq_e  seq_q, seq_d;
    logic [14:0]        cnt_q, cnt_d;
    logic               fast_q, fast_d;
    logic [4:0]         good_q, good_d, bad_q, bad_d;
    logic               dlock_q, dlock_d;
    logic               trig, cal_go;
    logic [2:0]         cur_d;
    logic               hiz_d, tune_d, lock_d;

    // Fast-lock terminal count from field
    function automatic logic [14:0] fast_term(input logic [3:0] f);
        fast_term = {1'b0, `SLC_FAST_BASE + 14'(f) * `SLC_FAST_STEP};
    endfunction

    // Calibration terminal count, one less than the length in comparison periods
    function automatic logic [14:0] cal_term(input logic [3:0] c);
        logic [14:0] p;
        p = 15'h0001 << c;
        cal_term = (`SLC_CAL_OFS + p) * `SLC_CAL_MUL + `SLC_CAL_ADD - 15'h0001;
    endfunction

    assign trig   = reg_wr_i && (reg_addr_i == `SLC_ADDR_INT);
    // Calibration only with mode high bit clear and the pin up
    assign cal_go = trig && power_down_n_i && !func_q[`SLC_MODE_HI];

    // Register writes and commit on integer write
    always_comb begin
        int_d  = int_q;
        num_d  = num_q;
        den_d  = den_q;
        func_d = func_q;
        cnum_d = cnum_q;
        cden_d = cden_q;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `SLC_ADDR_INT: begin
                    int_d  = reg_data_i;
                    cnum_d = num_q[`SLC_FIELD_HI:0];
                    cden_d = den_q[`SLC_FIELD_HI:0];
                end
                `SLC_ADDR_NUM: num_d = reg_data_i;
                `SLC_ADDR_DEN: den_d = reg_data_i;
                `SLC_ADDR_FUNC: func_d = reg_data_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            int_q  <= `SLC_WORD_RST;
            num_q  <= `SLC_WORD_RST;
            den_q  <= `SLC_WORD_RST;
            func_q <= `SLC_WORD_RST;
            cnum_q <= 12'h000;
            cden_q <= 12'h000;
        end else begin
            int_q  <= int_d;
            num_q  <= num_d;
            den_q  <= den_d;
            func_q <= func_d;
            cnum_q <= cnum_d;
            cden_q <= cden_d;
        end
    end

    // Calibration and fast-lock sequencer
    always_comb begin
        seq_d  = seq_q;
        cnt_d  = cnt_q;
        fast_d = fast_q;
        if (!power_down_n_i) begin
            seq_d = slc_pkg::SLC_IDLE;
        end else if (trig) begin
            fast_d = func_q[`SLC_SPEEDUP_ENABLE_BIT];
            cnt_d  = 15'h0000;
            if (cal_go) begin
                seq_d = slc_pkg::SLC_CAL;
            end else begin
                seq_d = func_q[`SLC_SPEEDUP_ENABLE_BIT] ? slc_pkg::SLC_FAST : slc_pkg::SLC_RUN;
            end
        end else if (pfd_tick_i) begin
            unique case (seq_q)
                slc_pkg::SLC_IDLE: ;
                slc_pkg::SLC_CAL: begin
                    if (cnt_q >= cal_term(func_q[`SLC_CALIBRATION_TIME_SEL_HI:`SLC_CALIBRATION_TIME_SEL_LO])) begin
                        cnt_d = 15'h0000;
                        seq_d = fast_q ? slc_pkg::SLC_FAST : slc_pkg::SLC_RUN;
                    end else begin
                        cnt_d = cnt_q + 15'h0001;
                    end
                end
                slc_pkg::SLC_FAST: begin
                    if (cnt_q >= fast_term(func_q[`SLC_FAST_HI:`SLC_FAST_LO])) begin
                        seq_d = slc_pkg::SLC_RUN;
                    end else begin
                        cnt_d = cnt_q + 15'h0001;
                    end
                end
                slc_pkg::SLC_RUN: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            seq_q  <= slc_pkg::SLC_IDLE;
            cnt_q  <= 15'h0000;
            fast_q <= 1'b0;
        end else begin
            seq_q  <= seq_d;
            cnt_q  <= cnt_d;
            fast_q <= fast_d;
        end
    end

    // Digital lock detector with consecutive counts
    always_comb begin
        logic [4:0] n_lock;
        logic [4:0] n_loss;
        n_lock  = func_q[`SLC_LDCNT_BIT] ? `SLC_LOCK_N1 : `SLC_LOCK_N0;
        n_loss  = func_q[`SLC_LDCNT_BIT] ? `SLC_UNLOCK_N1 : `SLC_UNLOCK_N0;
        good_d  = good_q;
        bad_d   = bad_q;
        dlock_d = dlock_q;
        if (trig) begin
            good_d  = 5'h00;
            bad_d   = 5'h00;
            dlock_d = 1'b0;
        end else if (pfd_tick_i && seq_q != slc_pkg::SLC_CAL) begin
            if (phase_good_i) begin
                bad_d  = 5'h00;
                good_d = (good_q == n_lock) ? good_q : good_q + 5'h01;
                if (good_q + 5'h01 >= n_lock) begin
                    dlock_d = 1'b1;
                end
            end else begin
                good_d = 5'h00;
                bad_d  = (bad_q == n_loss) ? bad_q : bad_q + 5'h01;
                if (dlock_q && bad_q + 5'h01 >= n_loss) begin
                    dlock_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            good_q  <= 5'h00;
            bad_q   <= 5'h00;
            dlock_q <= 1'b0;
        end else begin
            good_q  <= good_d;
            bad_q   <= bad_d;
            dlock_q <= dlock_d;
        end
    end

    // Output controls computed from state
    always_comb begin
        cur_d  = (seq_d == slc_pkg::SLC_FAST) ? num_d[`SLC_CPB_HI:`SLC_CPB_LO]
                                              : num_d[`SLC_CPN_HI:`SLC_CPN_LO];
        tune_d = (seq_d == slc_pkg::SLC_CAL);
        hiz_d  = func_d[`SLC_HIZ_BIT] || tune_d;
        lock_d = func_d[`SLC_LDSEL_BIT] ? phase_raw_i : dlock_d;
    end

    // Registered outputs
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            whole_divide_o       <= 12'h000;
            numerator_value_o    <= 12'h000;
            denominator_value_o  <= 12'h000;
            sigma_delta_enable_o <= 1'b0;
            local_mode_o         <= 2'h0;
            local_out_level_o    <= 2'h0;
            local_port_enable_o  <= 1'b0;
            pump_current_o       <= 3'h0;
            pump_tristate_o      <= 1'b0;
            tune_to_reference_o  <= 1'b0;
            calibrating_o        <= 1'b0;
            speedup_active_o     <= 1'b0;
            lock_indicator_o     <= 1'b0;
        end else begin
            whole_divide_o       <= int_d[`SLC_FIELD_HI:0];
            numerator_value_o    <= cnum_d;
            denominator_value_o  <= cden_d;
            sigma_delta_enable_o <= func_d[`SLC_DSM_BIT];
            local_mode_o         <= func_d[`SLC_MODE_HI:`SLC_MODE_LO];
            local_out_level_o    <= func_d[`SLC_LVL_HI:`SLC_LVL_LO];
            local_port_enable_o  <= (func_d[`SLC_MODE_HI:`SLC_MODE_LO] == 2'h1);
            pump_current_o       <= cur_d;
            pump_tristate_o      <= hiz_d;
            tune_to_reference_o  <= tune_d;
            calibrating_o        <= tune_d;
            speedup_active_o     <= (seq_d == slc_pkg::SLC_FAST);
            lock_indicator_o     <= lock_d;
        end
    end

    // Checks
    sequence trig_s;
        trig && power_down_n_i && !func_q[`SLC_MODE_HI];
    endsequence
    cal_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        trig_s |=> calibrating_o && pump_tristate_o) else $error("no calibration after trigger");
    setup_unlock_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        trig && !func_q[`SLC_LDSEL_BIT] |=> !lock_indicator_o) else $error("lock kept after setup");
    boost_cur_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        speedup_active_o |-> pump_current_o == num_q[`SLC_CPB_HI:`SLC_CPB_LO]) else $error("boost current wrong");
    norm_cur_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !speedup_active_o |-> pump_current_o == num_q[`SLC_CPN_HI:`SLC_CPN_LO]) else $error("normal current wrong");
    no_mode3_cal_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        trig && func_q[`SLC_MODE_HI] |=> !calibrating_o) else $error("calibration in external mode");
    commit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        trig |=> numerator_value_o == $past(num_q[`SLC_FIELD_HI:0])) else $error("numerator not committed");
    hiz_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        func_q[`SLC_HIZ_BIT] |-> pump_tristate_o) else $error("pump not tristated");
    raw_lock_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        func_d[`SLC_LDSEL_BIT] |=> lock_indicator_o == $past(phase_raw_i)) else $error("raw lock not routed");
    sdm_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sigma_delta_enable_o == func_q[`SLC_DSM_BIT]) else $error("modulator enable wrong");
endmodule // slc_synth_ctrl

// *** verification/slc_host_model.sv ***
// Host model that writes the control words and drives the power pin
`timescale 1ns/100ps
module slc_host_model (
    // Clock
    input  wire logic        clk_sys_i,
    // Register words and pin
    output logic             reg_wr_o,
    output logic [3:0]       reg_addr_o,
    output logic [19:0]      reg_data_o,
    output logic             power_down_n_o
);
    // Bus idle, device held down while supplies rise
    initial begin
        reg_wr_o       = 1'b0;
        reg_addr_o     = 4'h0;
        reg_data_o     = 20'h00000;
        power_down_n_o = 1'b0;
    end

    // One word, launched after a falling edge, then lines scrambled
    task automatic wr(input logic [3:0] a, input logic [19:0] d);
        @(negedge clk_sys_i);
        reg_wr_o   = 1'b1;
        reg_addr_o = a;
        reg_data_o = d;
        @(negedge clk_sys_i);
        reg_wr_o   = 1'b0;
        reg_addr_o = ~a;
        reg_data_o = ~d;
    endtask

    // Pin raised, then bias settling of 500 us before any trigger
    task automatic pin_up();
        @(negedge clk_sys_i);
        power_down_n_o = 1'b1;
        repeat (62500) @(negedge clk_sys_i);
    endtask
endmodule // slc_host_model

// *** verification/slc_synth_ctrl_tb.sv ***
// Self-checking bench of the synthesizer control block
`timescale 1ns/100ps
`include "slc_consts.svh"
module slc_synth_ctrl_tb;
    // Design connections
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, reg_wr_i, power_down_n_i;
    logic        pfd_tick_i = 1'b0, phase_good_i = 1'b0, phase_raw_i = 1'b0;
    logic [3:0]  reg_addr_i;
    logic [19:0] reg_data_i;
    logic [11:0] whole_divide_o, numerator_value_o, denominator_value_o;
    logic [2:0]  pump_current_o;
    logic [1:0]  local_mode_o, local_out_level_o;
    logic        sigma_delta_enable_o, local_port_enable_o, pump_tristate_o, tune_to_reference_o;
    logic        calibrating_o, speedup_active_o, lock_indicator_o;
    // Notes and bench state
    logic [35:0] q_set[$];
    int          q_cal[$], q_fast[$], q_lock[$];
    logic [19:0] nw = 20'h00000, dw = 20'h00000, fw = 20'h00000;
    logic        cal_q = 1'b0, spd_q = 1'b0, lock_q = 1'b0, good_q = 1'b0, raw_q = 1'b0, ana = 1'b0;
    logic [1:0]  wk = 2'h0;
    integer      seed = 32'hCFB9;
    int          fail_count = 0, compares = 0, tk = 0, run_n = 0, cal_n = 0, fast_n = 0;
    localparam int CAL = (6 + 2) * 8 + 3;

    always #4 clk_sys_i = ~clk_sys_i;

    slc_synth_ctrl DUT (.clk_sys_i, .rst_n_i, .reg_wr_i, .reg_addr_i, .reg_data_i, .power_down_n_i,
        .pfd_tick_i, .phase_good_i, .phase_raw_i, .whole_divide_o, .numerator_value_o,
        .denominator_value_o, .sigma_delta_enable_o, .local_mode_o, .local_out_level_o,
        .local_port_enable_o, .pump_current_o, .pump_tristate_o, .tune_to_reference_o,
        .calibrating_o, .speedup_active_o, .lock_indicator_o);
    slc_host_model host (.clk_sys_i, .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i), .reg_data_o(reg_data_i),
        .power_down_n_o(power_down_n_i));

    // Comparison of design values
    task automatic chk_val(input string n, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Comparison of tick counts
    task automatic chk_cnt(input string n, input int e, input int g);
        compares++;
        if (g != e) begin
            fail_count++;
            $display("wrong value %s expected %0d seen %0d", n, e, g);
        end
    endtask

    // Watcher: counts ticks per phase, compares each result with the oldest note
    always @(posedge clk_sys_i) begin
        if (wk == 2'h1) chk_val("divide", q_set.size() ? q_set.pop_front() : 'x,
            {whole_divide_o, numerator_value_o, denominator_value_o});
        if (wk == 2'h2) chk_val("func", q_set.size() ? q_set.pop_front() : 'x, {sigma_delta_enable_o,
            local_mode_o, local_out_level_o, local_port_enable_o, pump_tristate_o});
        wk = !reg_wr_i ? 2'h0 : reg_addr_i == `SLC_ADDR_INT ? 2'h1
            : reg_addr_i inside {`SLC_ADDR_NUM, `SLC_ADDR_DEN} ? 2'h0 : 2'h2;
        if (calibrating_o && !cal_q) chk_val("isolate", 36'h3, {tune_to_reference_o, pump_tristate_o});
        if (!calibrating_o && cal_q) chk_cnt("cal", q_cal.size() ? q_cal.pop_front() : -1, cal_n);
        cal_n = calibrating_o ? (cal_q ? cal_n : 0) + pfd_tick_i : 0;
        if (speedup_active_o && !spd_q) chk_val("boost", nw[14:12], pump_current_o);
        if (!speedup_active_o && spd_q) begin
            chk_cnt("fast", q_fast.size() ? q_fast.pop_front() : -1, fast_n);
            chk_val("normal", nw[18:16], pump_current_o);
        end
        fast_n = speedup_active_o ? (spd_q ? fast_n : 0) + pfd_tick_i : 0;
        if (ana) chk_val("lock_raw", raw_q, lock_indicator_o);
        else if (lock_indicator_o !== lock_q) chk_cnt("lock", q_lock.size() ? q_lock.pop_front() : -1,
            run_n * 2 + lock_indicator_o);
        if (reg_wr_i && reg_addr_i == `SLC_ADDR_INT) run_n = 0;
        else if (phase_good_i !== good_q) run_n = pfd_tick_i;
        else run_n += pfd_tick_i && !calibrating_o;
        {cal_q, spd_q, lock_q, good_q, raw_q} = {calibrating_o, speedup_active_o, lock_indicator_o,
            phase_good_i, phase_raw_i};
    end

    // Comparison ticks, one in four cycles
    always @(negedge clk_sys_i) begin
        tk++;
        pfd_tick_i = tk % 4 == 0;
    end

    // Register write that notes the expected settings
    task automatic put(input logic [3:0] a, input logic [19:0] d);
        if (a == `SLC_ADDR_INT) q_set.push_back({d[11:0], nw[11:0], dw[11:0]});
        else if (a == `SLC_ADDR_NUM) nw = d;
        else if (a == `SLC_ADDR_DEN) dw = d;
        else begin
            if (a == `SLC_ADDR_FUNC) fw = d;
            q_set.push_back({fw[5], fw[3:2], fw[1:0], fw[3:2] == 2'h1, fw[6]});
        end
        host.wr(a, d);
    endtask

    // Function word with random tristate, modulator and level bits
    function automatic logic [19:0] fn(logic lcs, logic ld, logic spd, logic [3:0] fast, logic [1:0] mode);
        logic [31:0] r;
        r = $random(seed);
        return {4'h1, 1'b0, lcs, ld, 1'b0, spd, fast, r[6:4], mode, r[1:0]};
    endfunction

    // Trigger with notes for calibration and fast-lock length
    task automatic trig(input int nc, input int nf);
        if (nc > 0) q_cal.push_back(nc);
        if (nf > 0) q_fast.push_back(nf);
        put(`SLC_ADDR_INT, {8'h00, 12'h023 + 12'({$random(seed)} % 32'hFD9)});
        repeat (nc * 4 + nf * 4 + 40) @(negedge clk_sys_i);
    endtask

    // Bounded wait for a lock level
    task automatic wl(input logic v);
        repeat (200) begin
            @(negedge clk_sys_i);
            if (lock_indicator_o === v) break;
        end
    endtask

    // Verdict and end of run
    task automatic stop_test();
        if (q_set.size() + q_cal.size() + q_fast.size() + q_lock.size() > 0) fail_count++;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        fail_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [11:0] m;
        repeat (12) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        m = 12'h002 + 12'({$random(seed)} % 32'hFFE);
        put(`SLC_ADDR_NUM, {1'b0, 3'($random(seed)), 1'b0, 3'($random(seed)), 12'({$random(seed)} % m)});
        put(`SLC_ADDR_DEN, {8'h01, m});
        put(`SLC_ADDR_FUNC, fn(1'b0, 1'b0, 1'b0, 4'h0, 2'h0));
        trig(0, 0);
        host.pin_up();
        trig(CAL, 0);
        put(`SLC_ADDR_FUNC, fn(1'b0, 1'b1, 1'b0, 4'h0, 2'h0));
        ana = 1'b1;
        repeat (20) @(negedge clk_sys_i) phase_raw_i = $random(seed);
        phase_raw_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        ana = 1'b0;
        for (int i = 0; i < 4; i++) put(`SLC_ADDR_FUNC, fn(1'b0, 1'b0, 1'b0, 4'h0, 2'(i)));
        put(4'h5, 20'hFFFFF);
        put(4'h0, 20'hFFFFF);
        put(`SLC_ADDR_FUNC, fn(1'b0, 1'b0, 1'b0, 4'h0, 2'h2));
        trig(0, 0);
        repeat (300) @(negedge clk_sys_i);
        for (int s = 0; s < 2; s++) begin
            put(`SLC_ADDR_FUNC, fn(s[0], 1'b0, 1'b0, 4'h0, 2'h0));
            phase_good_i = 1'b1;
            q_lock.push_back(s ? 63 : 31);
            trig(CAL, 0);
            wl(1'b1);
            if (s) begin
                q_lock.push_back(0);
                q_lock.push_back(63);
                trig(CAL, 0);
                wl(1'b1);
            end
            phase_good_i = 1'b0;
            q_lock.push_back(s ? 14 : 6);
            wl(1'b0);
        end
        for (int f = 0; f < 2; f++) begin
            put(`SLC_ADDR_FUNC, fn(1'b0, 1'b0, 1'b1, 4'(f), 2'h0));
            trig(CAL, 511 + f * 512 + 1);
        end
        stop_test();
    end
endmodule // slc_synth_ctrl_tb
